// file: hdl/tfpi_pkg.sv
// tfpi_pkg: constants and types shared by the time-multiplexed fir filter.
// assumes a single 200 MHz processing clock; the sample rate is set by the input handshake.
package tfpi_pkg;

  // ----------------------------------------------------------------
  // datapath shape
  // ----------------------------------------------------------------
  localparam int DATA_W = 18; // sample width
  localparam int COEF_W = 18; // coefficient width
  localparam int TAPS = 8; // prototype filter length
  localparam int TDM = 2; // sub-cycles per sample (interpolation factor in polyphase mode)
  localparam int NMUL = 4; // shared multipliers
  localparam int FIFO_DEPTH = 4; // rate-matching sample buffer

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_READY = 1'b0; // s_ready low while in reset
  localparam logic RST_MODE = 1'b0; // plain fir mode after reset

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    TFPI_IDLE = 1'b0,
    TFPI_RUN = 1'b1
  } tfpi_state_e;

endpackage

// file: hdl/tfpi_mac4.sv
// tfpi_mac4: bank of shared multipliers with enabled operand registers and an adder tree.
// assumes the caller presents operands and ld_en on the same clock; the sum is combinational.
`timescale 1ns/1ps
`default_nettype none

module tfpi_mac4 #(
  parameter int NMUL = 4,
  parameter int DW = 18,
  parameter int CW = 18,
  parameter int SW = 38
) (
  input wire logic clk, // processing clock
  input wire logic rstn, // async reset, active low
  input wire logic ld_en, // load operand registers
  input wire logic signed [DW-1:0] x_in [NMUL], // samples
  input wire logic signed [CW-1:0] c_in [NMUL], // coefficients
  output logic signed [SW-1:0] psum // sum of the products
);

  localparam int PW = DW + CW;

  logic signed [DW-1:0] x_q [NMUL];
  logic signed [DW-1:0] x_d [NMUL];
  logic signed [CW-1:0] c_q [NMUL];
  logic signed [CW-1:0] c_d [NMUL];
  logic signed [PW-1:0] prod [NMUL];

  initial begin
    if (SW < PW + $clog2(NMUL)) begin
      $error("tfpi_mac4: sum width too small");
    end
  end

  // ----------------------------------------------------------------
  // operand registers: only the enabled set takes new values
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NMUL; i++) begin
      x_d[i] = ld_en ? x_in[i] : x_q[i];
      c_d[i] = ld_en ? c_in[i] : c_q[i];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NMUL; i++) begin
        x_q[i] <= '0;
        c_q[i] <= '0;
      end
    end else begin
      x_q <= x_d;
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // products and adder tree
  // ----------------------------------------------------------------
  always_comb begin
    psum = '0;
    for (int i = 0; i < NMUL; i++) begin
      prod[i] = x_q[i] * c_q[i];
      psum = psum + SW'(prod[i]);
    end
  end

endmodule // tfpi_mac4

`default_nettype wire

// file: hdl/tfpi_top.sv
// tfpi_top: time-multiplexed fir with optional polyphase interpolation, one clock.
// assumes upstream and downstream logic share clk; the output stream has no back-pressure.
//
// Contract
// - even sub-cycle loads odd-indexed coefficients with matching samples; sums four products.
// - even sub-cycle partial sum is held in a register outside the multiplier bank.
// - odd sub-cycle loads even-indexed coefficients; sum plus held partial is the output.
// - the load, store, add pattern repeats, one full output per sub-cycle pair.
// - for factors above two an accumulator sums all sub-cycle partials of a sample.
// - the accumulator lives in general logic outside the multiplier bank.
// - the accumulator restarts from zero at the first sub-cycle of each sample.
// - a fifo written at sample rate feeds the multipliers at the faster rate.
// - interpolation conceptually inserts factor-minus-one zero samples between inputs.
// - products of the inserted zero samples are never computed.
// - sub-filter k uses coefficient h(k + n*I) at tap n.
// - prototype length is a multiple of the factor; each sub-filter has L/I taps.
// - samples and coefficients are 18 bits; 8 taps with factor two by default.
// - delay line shifts once per sample; coefficients and multipliers load every cycle while the sequencer runs and hold while it is idle.
`timescale 1ns/1ps
`default_nettype none

module tfpi_top #(
  parameter int DW = tfpi_pkg::DATA_W,
  parameter int CW = tfpi_pkg::COEF_W,
  parameter int TAPS = tfpi_pkg::TAPS,
  parameter int TDM = tfpi_pkg::TDM,
  parameter int NMUL = tfpi_pkg::NMUL,
  parameter int FD = tfpi_pkg::FIFO_DEPTH
) (
  input wire logic clk, // 200 MHz processing clock
  input wire logic rstn, // async reset, active low
  input wire logic s_valid, // sample offered
  input wire logic signed [DW-1:0] s_data, // sample value
  output logic s_ready, // fifo can take a sample
  input wire logic interp_mode, // 1: polyphase interpolation, 0: plain fir
  input wire logic coef_we, // coefficient write strobe
  input wire logic [$clog2(TAPS)-1:0] coef_idx, // coefficient index h(idx)
  input wire logic signed [CW-1:0] coef_data, // coefficient value
  output logic y_valid, // one-cycle output strobe
  output logic signed [DW+CW+$clog2(TAPS)-1:0] y_data, // filter output
  output logic [$clog2(TDM)-1:0] y_phase // sub-filter index in interpolation mode
);

  localparam int PW = DW + CW;
  localparam int SW = PW + $clog2(NMUL);
  localparam int OW = PW + $clog2(TAPS);
  localparam int PHW = $clog2(TDM);
  localparam int TW = $clog2(TAPS);
  localparam int AW = $clog2(FD);
  localparam int CNW = $clog2(FD + 1);
  localparam logic [PHW-1:0] PH_LAST = PHW'(TDM - 1);

  initial begin
    if (TDM < 2 || TAPS != NMUL * TDM || FD < 2 || (FD & (FD - 1)) != 0)
      $error("tfpi_top: need TDM >= 2, TAPS = NMUL*TDM, FD a power of two");
  end

  // ----------------------------------------------------------------
  // tap mapping
  // ----------------------------------------------------------------
  // plain fir: sub-cycle p serves taps m*TDM + (TDM-1-p), so odd taps come first
  function automatic logic [TW-1:0] coef_sel(input int m, input logic [PHW-1:0] p, input logic intp);
    coef_sel = intp ? TW'(m * TDM + int'(p)) : TW'(m * TDM + (TDM - 1 - int'(p)));
  endfunction
  // interpolation reads only real samples, never the padded zeros
  function automatic logic [TW-1:0] samp_sel(input int m, input logic [PHW-1:0] p, input logic intp);
    samp_sel = intp ? TW'(m) : TW'(m * TDM + (TDM - 1 - int'(p)));
  endfunction

  // ----------------------------------------------------------------
  // coefficient store
  // ----------------------------------------------------------------
  logic signed [CW-1:0] coef_q [TAPS];
  logic signed [CW-1:0] coef_d [TAPS];

  always_comb begin
    coef_d = coef_q;
    if (coef_we) coef_d[coef_idx] = coef_data;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coef_q <= '{default: '0};
    end else begin
      coef_q <= coef_d;
    end
  end

  // ----------------------------------------------------------------
  // rate-matching fifo and sequencer
  // ----------------------------------------------------------------
  // the buffer absorbs bursts; the sequencer drains one sample per TDM cycles
  logic signed [DW-1:0] mem_q [FD];
  logic signed [DW-1:0] mem_d [FD];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CNW-1:0] cnt_q, cnt_d;
  logic s_ready_q, s_ready_d;
  logic push, pop;
  tfpi_pkg::tfpi_state_e st_q, st_d;
  logic [PHW-1:0] ph_q, ph_d;
  logic mode_q, mode_d;
  logic signed [DW-1:0] dly_q [TAPS];
  logic signed [DW-1:0] dly_d [TAPS];

  always_comb begin
    push = s_valid && s_ready_q;
    pop = 1'b0;
    st_d = st_q;
    ph_d = ph_q;
    mode_d = mode_q;
    if (st_q == tfpi_pkg::TFPI_IDLE || ph_q == PH_LAST) begin
      if (cnt_q != '0) begin
        pop = 1'b1;
        st_d = tfpi_pkg::TFPI_RUN;
        ph_d = '0;
        mode_d = interp_mode;
      end else begin
        st_d = tfpi_pkg::TFPI_IDLE;
      end
    end else begin
      ph_d = ph_q + PHW'(1);
    end
    mem_d = mem_q;
    if (push) begin
      mem_d[wp_q] = s_data;
    end
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + CNW'(push) - CNW'(pop);
    s_ready_d = (cnt_d < CNW'(FD));
    dly_d = dly_q;
    if (pop) begin
      dly_d[0] = mem_q[rp_q];
      for (int i = 1; i < TAPS; i++) begin
        dly_d[i] = dly_q[i-1];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_q <= '{default: '0};
      dly_q <= '{default: '0};
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      s_ready_q <= tfpi_pkg::RST_READY;
      st_q <= tfpi_pkg::TFPI_IDLE;
      ph_q <= '0;
      mode_q <= tfpi_pkg::RST_MODE;
    end else begin
      mem_q <= mem_d;
      dly_q <= dly_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      s_ready_q <= s_ready_d;
      st_q <= st_d;
      ph_q <= ph_d;
      mode_q <= mode_d;
    end
  end

  assign s_ready = s_ready_q;

  // ----------------------------------------------------------------
  // operand selection and shared multipliers
  // ----------------------------------------------------------------
  logic signed [DW-1:0] x_sel [NMUL];
  logic signed [CW-1:0] c_sel [NMUL];
  logic signed [SW-1:0] psum;
  logic ld_en;

  always_comb begin
    for (int m = 0; m < NMUL; m++) begin
      x_sel[m] = dly_q[samp_sel(m, ph_q, mode_q)];
      c_sel[m] = coef_q[coef_sel(m, ph_q, mode_q)];
    end
    ld_en = (st_q == tfpi_pkg::TFPI_RUN);
  end

  tfpi_mac4 #(
    .NMUL(NMUL),
    .DW(DW),
    .CW(CW),
    .SW(SW)
  ) u_mac (
    .clk(clk),
    .rstn(rstn),
    .ld_en(ld_en),
    .x_in(x_sel),
    .c_in(c_sel),
    .psum(psum)
  );

  // ----------------------------------------------------------------
  // accumulator and output, in general logic beside the multipliers
  // ----------------------------------------------------------------
  logic op_vld_q, op_vld_d, op_int_q, op_int_d;
  logic [PHW-1:0] op_ph_q, op_ph_d;
  logic signed [OW-1:0] acc_q, acc_d, y_q, y_d, psum_x;
  logic y_vld_q, y_vld_d;
  logic [PHW-1:0] yph_q, yph_d;

  always_comb begin
    op_vld_d = ld_en;
    op_ph_d = ph_q;
    op_int_d = mode_q;
    psum_x = OW'(psum);
    acc_d = acc_q;
    y_d = y_q;
    yph_d = yph_q;
    y_vld_d = 1'b0;
    if (op_vld_q) begin
      if (op_int_q) begin
        y_d = psum_x;
        yph_d = op_ph_q;
        y_vld_d = 1'b1;
      end else begin
        acc_d = (op_ph_q == '0) ? psum_x : acc_q + psum_x;
        if (op_ph_q == PH_LAST) begin
          y_d = acc_q + psum_x;
          yph_d = '0;
          y_vld_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_vld_q <= 1'b0;
      op_ph_q <= '0;
      op_int_q <= 1'b0;
      acc_q <= '0;
      y_q <= '0;
      yph_q <= '0;
      y_vld_q <= 1'b0;
    end else begin
      op_vld_q <= op_vld_d;
      op_ph_q <= op_ph_d;
      op_int_q <= op_int_d;
      acc_q <= acc_d;
      y_q <= y_d;
      yph_q <= yph_d;
      y_vld_q <= y_vld_d;
    end
  end

  assign y_valid = y_vld_q;
  assign y_data = y_q;
  assign y_phase = yph_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_ODD_SET: assert property ((ld_en && !mode_q && ph_q == '0) |->
    (c_sel[0] == coef_q[TDM-1] && x_sel[0] == dly_q[TDM-1] && c_sel[NMUL-1] == coef_q[TAPS-1]))
    else $error("sub-cycle zero does not load the odd tap set");
  AST_EVEN_SET: assert property ((ld_en && !mode_q && ph_q == PH_LAST) |->
    (c_sel[0] == coef_q[0] && x_sel[0] == dly_q[0] && c_sel[NMUL-1] == coef_q[TAPS-TDM]))
    else $error("last sub-cycle does not load the even tap set");
  AST_HOLD: assert property (!op_vld_q |=> $stable(acc_q))
    else $error("held partial sum changed with no work");
  AST_CLEAR: assert property ((op_vld_q && !op_int_q && op_ph_q == '0) |=> acc_q == $past(psum_x))
    else $error("accumulator not restarted at sub-cycle zero");
  AST_SUM: assert property ((op_vld_q && !op_int_q && op_ph_q == PH_LAST) |=>
    (y_valid && y_data == $past(acc_q) + $past(psum_x)))
    else $error("output is not held partial plus final partial");
  AST_CADENCE: assert property ((y_valid && !$past(op_int_q)) |=> !y_valid)
    else $error("plain fir produced outputs closer than one per sample");
  AST_FIFO: assert property ((cnt_q == CNW'(FD)) |-> (!s_ready && !push))
    else $error("full fifo still accepting");
  AST_POP: assert property (pop |-> (cnt_q != '0 ##1 (st_q == tfpi_pkg::TFPI_RUN && ph_q == '0)))
    else $error("sample taken from empty fifo or not aligned to sub-cycle zero");
  AST_SHIFT: assert property (!pop |=> (dly_q[0] == $past(dly_q[0])))
    else $error("delay line moved without a new sample");
  AST_POLY: assert property ((op_vld_q && op_int_q) |=> (y_valid && y_phase == $past(op_ph_q)))
    else $error("polyphase output missing or wrong sub-filter");

  COV_FIR_OUT: cover property (op_vld_q && !op_int_q ##1 op_vld_q ##1 y_valid);
  COV_POLY_OUT: cover property (y_valid && y_phase == PH_LAST);
  COV_FIFO_FULL: cover property (cnt_q == CNW'(FD));

endmodule // tfpi_top

`default_nettype wire

// file: verif/tfpi_src.sv
// tfpi_src: upstream sample source for the filter bench.
// assumes it shares clk with the filter and drives at the rising edge.
`timescale 1ns/1ps
`default_nettype none

module tfpi_src #(
  parameter int DW = 18
) (
  input wire logic clk, // processing clock
  input wire logic rstn, // async reset, active low
  input wire logic en, // offer a new sample when free
  input wire logic signed [DW-1:0] nxt, // value of the next sample
  input wire logic s_ready, // filter can take a sample
  output logic s_valid, // sample offered
  output logic signed [DW-1:0] s_data // sample value
);
  // ------------------------------------------------------------
  // source
  // ------------------------------------------------------------
  // an offer is held until taken; an idle data line toggles so a stale value never passes for data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_valid <= 1'b0;
      s_data <= '1;
    end else if (!s_valid || s_ready) begin
      s_valid <= en;
      s_data <= en ? nxt : ~s_data;
    end
  end
endmodule // tfpi_src
`default_nettype wire

// file: verif/tb_tfpi_top.sv
// tb_tfpi_top: self-checking bench for the time-multiplexed fir filter.
// assumes default package sizes; expected outputs come from an integer model of the accepted samples.
`timescale 1ns/1ps
`default_nettype none

module tb_tfpi_top;
  localparam int DW = tfpi_pkg::DATA_W;
  localparam int CW = tfpi_pkg::COEF_W;
  localparam int OW = DW + CW + $clog2(tfpi_pkg::TAPS);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b0;
  logic signed [DW-1:0] nxt = 18'h00000;
  logic s_valid, s_ready, y_valid;
  logic signed [DW-1:0] s_data;
  logic interp_mode = 1'b0;
  logic coef_we = 1'b0;
  logic [2:0] coef_idx = 3'h0;
  logic signed [CW-1:0] coef_data = 18'h00000;
  logic signed [OW-1:0] y_data;
  logic [0:0] y_phase;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int last_y = 0;
  int seed;
  logic saw_full = 1'b0;
  longint h [8] = '{default: 0};
  longint hist [$];
  longint exq [$];
  logic [0:0] phq [$];

  tfpi_top i_dut (.clk(clk), .rstn(rstn), .s_valid(s_valid), .s_data(s_data), .s_ready(s_ready),
    .interp_mode(interp_mode), .coef_we(coef_we), .coef_idx(coef_idx), .coef_data(coef_data),
    .y_valid(y_valid), .y_data(y_data), .y_phase(y_phase));
  tfpi_src #(.DW(DW)) i_src (.clk(clk), .rstn(rstn), .en(en), .nxt(nxt), .s_ready(s_ready),
    .s_valid(s_valid), .s_data(s_data));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // checking and model
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // interp output k sums h(k+2m)*x(n-m); plain fir sums all eight taps
  task automatic accept(input longint x);
    longint acc;
    hist.push_front(x);
    hist = hist[0:7];
    for (int k = 0; k < (interp_mode ? 2 : 1); k++) begin
      acc = 0;
      for (int j = 0; j < 8; j++) begin
        if (!interp_mode || j % 2 == k) acc += h[j] * hist[interp_mode ? j / 2 : j];
      end
      exq.push_back(acc);
      phq.push_back(k[0]);
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_sim();
    end else if (rstn) begin
      if (!s_ready) saw_full = 1'b1;
      if (s_valid && s_ready) accept(s_data);
      if (y_valid === 1'b1) begin
        if (exq.size() == 0) begin
          check(64'h1, 64'h0);
        end else begin
          check(64'(y_data), exq.pop_front());
          check(y_phase, phq.pop_front());
          if (y_phase === 1'b1) check(64'(cyc - last_y), 64'h1);
          else if (!interp_mode) check(64'((cyc - last_y) >= 2), 64'h1);
        end
        last_y = cyc;
      end
    end
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    en <= 1'b0;
    @(posedge clk);
    hist = '{0, 0, 0, 0, 0, 0, 0, 0};
    exq.delete();
    phq.delete();
    h = '{default: 0};
    repeat (7) begin
      @(posedge clk);
      check(s_ready, 1'b0);
      check(y_valid, 1'b0);
    end
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    saw_full = 1'b0;
  endtask

  task automatic put_coef(input int i, input logic signed [CW-1:0] v);
    @(posedge clk);
    coef_we <= 1'b1;
    coef_idx <= i[2:0];
    coef_data <= v;
    h[i] = v;
    @(posedge clk);
    coef_we <= 1'b0;
  endtask

  // prompt keeps the source offering so the fifo fills; otherwise it stalls at random
  task automatic run(input int n, input bit prompt, input bit ext);
    repeat (n) begin
      @(posedge clk);
      en <= prompt ? 1'b1 : 1'($urandom % 2);
      nxt <= ext ? 18'h20000 : DW'($urandom);
    end
    @(posedge clk);
    en <= 1'b0;
    for (int i = 0; i < 400 && (s_valid !== 1'b0 || exq.size() > 0); i++) @(posedge clk);
    repeat (8) @(posedge clk);
    check(64'(exq.size()), 64'h0);
  endtask

  initial begin
    seed = $urandom(32'h3A58);
    do_reset();
    for (int i = 0; i < 8; i++) put_coef(i, CW'($urandom));
    run(24, 1'b1, 1'b0);
    check(saw_full, 1'b1);
    run(60, 1'b0, 1'b0);
    @(posedge clk);
    interp_mode <= 1'b1;
    run(24, 1'b1, 1'b0);
    run(60, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) put_coef(i, 18'h20000);
    run(16, 1'b1, 1'b1);
    @(posedge clk);
    interp_mode <= 1'b0;
    run(16, 1'b1, 1'b1);
    repeat (12) begin
      @(posedge clk);
      en <= 1'b1;
      nxt <= DW'($urandom);
    end
    do_reset();
    for (int i = 0; i < 8; i++) put_coef(i, CW'($urandom));
    run(30, 1'b0, 1'b0);
    end_sim();
  end
endmodule // tb_tfpi_top
`default_nettype wire
